//--- svsq_defs.svh
// Constants of the servo setup and sequence logic
`ifndef SVSQ_DEFS_SVH
`define SVSQ_DEFS_SVH

// ----------------------------------------------------------------------
// Setup word one: width, factory value, bit positions
// ----------------------------------------------------------------------
`define SVSQ_WORD_W        16
`define SVSQ_WORD_FACTORY  16'h00EC
`define SVSQ_B_SERVO       0
`define SVSQ_B_SENSOR      1
`define SVSQ_B_FWD         2
`define SVSQ_B_REV         3
`define SVSQ_B_FLAGSEL     4
`define SVSQ_B_DIPCLR      5
`define SVSQ_B_FREERUN     6
`define SVSQ_B_DBHOLD      7
`define SVSQ_B_OTTORQ      8
`define SVSQ_B_OTLOCK      9
`define SVSQ_IDX_MAX       4'hF

// ----------------------------------------------------------------------
// Alarm history and codes
// ----------------------------------------------------------------------
`define SVSQ_HIST_DEPTH    10
`define SVSQ_HIST_AW       4
`define SVSQ_HIST_LAST     4'h9
`define SVSQ_CODE_W        8
`define SVSQ_ALM_DIP_CODE  8'h10

// ----------------------------------------------------------------------
// Settings mode parameter numbers
// ----------------------------------------------------------------------
`define SVSQ_PSEL_SYSCHK   1'h0
`define SVSQ_PSEL_WORD1    1'h1

// ----------------------------------------------------------------------
// Synchroniser vector layout
// ----------------------------------------------------------------------
`define SVSQ_NKEY          8
`define SVSQ_SYNC_W        41
`define SVSQ_BOOT_CYC      2'h3

`endif

//--- svsq_hist_mem.sv
// Alarm history store, ten codes with registered read data
`timescale 1ns/10ps
`include "svsq_defs.svh"

module svsq_hist_mem (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [`SVSQ_HIST_AW-1:0] wr_addr,
  input  wire logic [`SVSQ_CODE_W-1:0]  wr_data,
  // Read port
  input  wire logic [`SVSQ_HIST_AW-1:0] rd_addr,
  output logic      [`SVSQ_CODE_W-1:0]  rd_data
);

  logic [`SVSQ_CODE_W-1:0] mem_r [0:`SVSQ_HIST_DEPTH-1];

  // Storage array, no reset needed since a count tracks valid entries
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Read data leave through a register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule

//--- svsq_nv_model.sv
// Nonvolatile store holding the setup word across power cycles
`timescale 1ns/10ps

module svsq_nv_model (
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Preset of the stored word, used only while power is off
  input  wire logic        ld,
  input  wire logic [15:0] ld_word,
  // Write port from the device
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  // Word read back at power-up
  output logic      [15:0] word
);
  logic [15:0] mem = 16'h00EC;

  // Saves land only on a write pulse
  // Read is refreshed only in power-up, so a save waits for it
  always @(posedge clk) begin
    if (ld) begin
      mem <= ld_word;
    end else if (wr) begin
      mem <= wdata;
    end
    if (!rst_b) begin
      word <= mem;
    end
  end
endmodule

//--- svsq_pkg.sv
// Types shared by the servo setup and sequence logic
`include "svsq_defs.svh"

package svsq_pkg;

  // Operating modes, advanced by the mode key
  typedef enum logic [1:0] {
    SVSQ_M_STATUS,
    SVSQ_M_SETTINGS,
    SVSQ_M_MONITOR,
    SVSQ_M_HISTORY
  } svsq_mode_e;

  // Status display symbols
  typedef enum logic [2:0] {
    SVSQ_S_BASEBLOCK,
    SVSQ_S_OPERATING,
    SVSQ_S_FWD_INHIBIT,
    SVSQ_S_REV_INHIBIT,
    SVSQ_S_ALARM
  } svsq_sym_e;

  // Display contents handed to the keypad unit
  typedef struct packed {
    svsq_mode_e                 mode;
    svsq_sym_e                  symbol;
    logic                       editing;
    logic [`SVSQ_CODE_W-1:0]    code;
    logic [`SVSQ_WORD_W-1:0]    word;
    logic [3:0]                 index;
  } svsq_disp_s;

endpackage

//--- svsq_top.sv
// Servo setup word editing, keypad modes and sequence decoding
`timescale 1ns/10ps

// Operation
// - Four modes; mode key steps status, settings, monitor, history.
// - Status mode shows baseblock, operating, inhibit or alarm symbol.
// - Up to ten past alarms kept, shown in history, cleared in settings.
// - Setup word shown as sixteen lit bits plus selected bit index.
// - Index keys move the selected bit; toggle key inverts it.
// - Save key alone commits the edit; data key then returns.
// - A saved word takes effect only after the next power-up.
// - Bit 0: servo by run command, or always on.
// - Bit 1: sensor-on input honoured, or forced high.
// - Bit 2: forward inhibit honoured, or forward always allowed.
// - Bit 3: reverse inhibit honoured, or reverse always allowed.
// - Bit 4: shared flag shows rotation or current limit.
// - Bit 5: power dip recovery raises alarm, or clears and resumes.
// - Bit 6: abnormal stop by dynamic brake, or free run.
// - Bit 7: brake released, or held, once the motor stops.
// - Bit 8: over-travel stop per bit 6, or emergency stop torque.
// - Bit 9: after over-travel stop, servo off or position lock.
// - Bit 6 set, bit 8 clear: brake released after stop, bit 7 ignored.
module svsq_top (
  // Clock and reset
  input  wire logic                        MCLK,
  input  wire logic                        RST_B,
  // Keypad keys, held high while pressed
  input  wire logic                        KEY_MODE,
  input  wire logic                        KEY_DATA,
  input  wire logic                        KEY_UP,
  input  wire logic                        KEY_DOWN,
  input  wire logic                        KEY_LEFT,
  input  wire logic                        KEY_RIGHT,
  input  wire logic                        KEY_SAVE,
  input  wire logic                        KEY_ALARM_RESET,
  // Sequence inputs from the host and the power stage
  input  wire logic                        RUN_CMD,
  input  wire logic                        SENSOR_ON,
  input  wire logic                        FORWARD_DRIVE_INHIBIT,
  input  wire logic                        REVERSE_DRIVE_INHIBIT,
  input  wire logic                        MOTOR_ROTATING,
  input  wire logic                        CURRENT_LIMIT,
  input  wire logic                        MOTOR_STOPPED,
  input  wire logic                        POWER_DIP,
  input  wire logic                        ALARM_IN,
  input  wire logic [`SVSQ_CODE_W-1:0]     ALARM_CODE,
  // Nonvolatile parameter memory
  input  wire logic [`SVSQ_WORD_W-1:0]     NV_WORD,
  output logic                             NV_WR,
  output logic      [`SVSQ_WORD_W-1:0]     NV_WDATA,
  // Sequence outputs
  output logic                             SERVO_ON,
  output logic                             SENSOR_ON_INT,
  output logic                             FWD_PERMIT,
  output logic                             REV_PERMIT,
  output logic                             ROTATION_OR_CURRENT_LIMIT_FLAG,
  output logic                             DYN_BRAKE,
  output logic                             ESTOP_TORQUE_SEL,
  output logic                             POS_LOCK,
  output logic                             SERVO_ALARM,
  // Display
  output svsq_pkg::svsq_disp_s             DISP
);
  import svsq_pkg::*;

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  logic [`SVSQ_SYNC_W-1:0] raw_in;
  logic [`SVSQ_SYNC_W-1:0] s1_r;
  logic [`SVSQ_SYNC_W-1:0] s2_r;
  logic [`SVSQ_NKEY-1:0]   key_d_r;
  logic [`SVSQ_NKEY-1:0]   key_p;

  assign raw_in = {NV_WORD, ALARM_CODE, ALARM_IN, POWER_DIP, MOTOR_STOPPED,
                   CURRENT_LIMIT, MOTOR_ROTATING, REVERSE_DRIVE_INHIBIT,
                   FORWARD_DRIVE_INHIBIT, SENSOR_ON, RUN_CMD,
                   KEY_ALARM_RESET, KEY_SAVE, KEY_RIGHT, KEY_LEFT,
                   KEY_DOWN, KEY_UP, KEY_DATA, KEY_MODE};

  // Every pin passes two flops before any logic sees it
  genvar gi;
  generate
    for (gi = 0; gi < `SVSQ_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= raw_in[gi];
          s2_r[gi] <= s1_r[gi];
        end
      end
    end
  endgenerate

  // Key presses become one-cycle pulses on the rising edge
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      key_d_r <= 8'h00;
    end else begin
      key_d_r <= s2_r[`SVSQ_NKEY-1:0];
    end
  end
  assign key_p = s2_r[`SVSQ_NKEY-1:0] & ~key_d_r;

  logic k_mode, k_data, k_up, k_down, k_left, k_right, k_save, k_arst;
  assign {k_arst, k_save, k_right, k_left, k_down, k_up, k_data, k_mode} =
    key_p;

  logic                     run_s, sens_s, fwd_s, rev_s, rot_s, clim_s;
  logic                     stop_s, dip_s, alm_s;
  logic [`SVSQ_CODE_W-1:0]  code_s;
  logic [`SVSQ_WORD_W-1:0]  nv_s;
  assign {nv_s, code_s, alm_s, dip_s, stop_s, clim_s, rot_s, rev_s, fwd_s,
          sens_s, run_s} = s2_r[`SVSQ_SYNC_W-1:`SVSQ_NKEY];

  // --------------------------------------------------------------------
  // Power-up load of the setup word
  // --------------------------------------------------------------------
  logic [1:0]              boot_r;
  logic                    booted_r;
  logic [`SVSQ_WORD_W-1:0] active_r;
  logic [`SVSQ_WORD_W-1:0] stored_r;
  logic [`SVSQ_WORD_W-1:0] edit_r;
  logic                    save_ok;

  // Wait until the memory word has crossed the synchroniser
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      boot_r   <= 2'h0;
      booted_r <= 1'b0;
    end else if (!booted_r) begin
      boot_r   <= boot_r + 2'h1;
      booted_r <= (boot_r == `SVSQ_BOOT_CYC);
    end
  end

  // Active copy loads once per power-up; saves never reach it
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      active_r <= `SVSQ_WORD_FACTORY;
    end else if (!booted_r && boot_r == `SVSQ_BOOT_CYC) begin
      active_r <= nv_s;
    end
  end

  // Shadow of the memory, so a reopened edit shows the saved value
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      stored_r <= `SVSQ_WORD_FACTORY;
    end else if (!booted_r && boot_r == `SVSQ_BOOT_CYC) begin
      stored_r <= nv_s;
    end else if (save_ok) begin
      stored_r <= edit_r;
    end
  end

  // --------------------------------------------------------------------
  // Keypad modes and setup word editing
  // --------------------------------------------------------------------
  svsq_mode_e mode_r;
  logic       psel_r;
  logic       edit_on_r;
  logic [3:0] idx_r;
  logic       hist_clr;

  // Mode key steps through the four modes and leaves any edit
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_r <= SVSQ_M_STATUS;
    end else if (k_mode) begin
      case (mode_r)
        SVSQ_M_STATUS:   mode_r <= SVSQ_M_SETTINGS;
        SVSQ_M_SETTINGS: mode_r <= SVSQ_M_MONITOR;
        SVSQ_M_MONITOR:  mode_r <= SVSQ_M_HISTORY;
        SVSQ_M_HISTORY:  mode_r <= SVSQ_M_STATUS;
        default:         mode_r <= SVSQ_M_STATUS;
      endcase
    end
  end

  assign save_ok  = booted_r && edit_on_r && k_save && !k_mode;
  assign hist_clr = (mode_r == SVSQ_M_SETTINGS) && !edit_on_r && k_data &&
                    !k_mode && psel_r == `SVSQ_PSEL_SYSCHK;

  // Parameter number selection and entry into the bit editor
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      psel_r    <= `SVSQ_PSEL_SYSCHK;
      edit_on_r <= 1'b0;
    end else if (k_mode || mode_r != SVSQ_M_SETTINGS) begin
      edit_on_r <= 1'b0;
    end else if (!edit_on_r) begin
      if (k_up || k_down) begin
        psel_r <= ~psel_r;
      end
      if (k_data && psel_r == `SVSQ_PSEL_WORD1) begin
        edit_on_r <= 1'b1;
      end
    end else if (k_data) begin
      edit_on_r <= 1'b0;
    end
  end

  // Edit copy: loaded on entry, bits moved and inverted by keys
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      edit_r <= `SVSQ_WORD_FACTORY;
      idx_r  <= 4'h0;
    end else if (!edit_on_r) begin
      edit_r <= stored_r;
      idx_r  <= 4'h0;
    end else begin
      if (k_left && idx_r != `SVSQ_IDX_MAX) begin
        idx_r <= idx_r + 4'h1;
      end else if (k_right && idx_r != 4'h0) begin
        idx_r <= idx_r - 4'h1;
      end
      if (k_up || k_down) begin
        edit_r[idx_r] <= ~edit_r[idx_r];
      end
    end
  end

  // Memory write strobe, one cycle per save
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      NV_WR    <= 1'b0;
      NV_WDATA <= `SVSQ_WORD_FACTORY;
    end else begin
      NV_WR <= save_ok;
      if (save_ok) begin
        NV_WDATA <= edit_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // Alarms and history
  // --------------------------------------------------------------------
  logic                     alm_d_r;
  logic                     dip_d_r;
  logic                     alarm_r;
  logic                     dip_alarm;
  logic                     alm_new;
  logic                     hist_we;
  logic [`SVSQ_CODE_W-1:0]  hist_wd;
  logic [`SVSQ_HIST_AW-1:0] wptr_r;
  logic [`SVSQ_HIST_AW-1:0] cnt_r;
  logic [`SVSQ_HIST_AW-1:0] hidx_r;
  logic [`SVSQ_HIST_AW-1:0] hrd;
  logic [`SVSQ_CODE_W-1:0]  hrdata;
  logic [`SVSQ_CODE_W-1:0]  alm_code_r;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      alm_d_r <= 1'b0;
      dip_d_r <= 1'b0;
    end else begin
      alm_d_r <= alm_s;
      dip_d_r <= dip_s;
    end
  end

  // Recovery from a power dip raises an alarm unless auto clear is set
  assign dip_alarm = dip_d_r && !dip_s &&
                     !active_r[`SVSQ_B_DIPCLR];
  assign alm_new   = (alm_s && !alm_d_r) || dip_alarm;
  assign hist_we   = alm_new && booted_r;
  assign hist_wd   = dip_alarm ? `SVSQ_ALM_DIP_CODE : code_s;

  // Latched alarm; a new event wins over the reset key
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      alarm_r    <= 1'b0;
      alm_code_r <= 8'h00;
    end else if (hist_we) begin
      alarm_r    <= 1'b1;
      alm_code_r <= hist_wd;
    end else if (k_arst && !alm_s) begin
      alarm_r    <= 1'b0;
    end
  end

  // Ring of ten entries; the oldest is overwritten once full
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      wptr_r <= 4'h0;
      cnt_r  <= 4'h0;
    end else if (hist_we) begin
      wptr_r <= (wptr_r == `SVSQ_HIST_LAST) ? 4'h0 : wptr_r + 4'h1;
      if (hist_clr) begin
        cnt_r <= 4'h1;
      end else if (cnt_r != 4'(`SVSQ_HIST_DEPTH)) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else if (hist_clr) begin
      cnt_r <= 4'h0;
    end
  end

  // Browse index in history mode, zero is the newest entry
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      hidx_r <= 4'h0;
    end else if (mode_r != SVSQ_M_HISTORY) begin
      hidx_r <= 4'h0;
    end else if (k_up && hidx_r != `SVSQ_HIST_LAST) begin
      hidx_r <= hidx_r + 4'h1;
    end else if (k_down && hidx_r != 4'h0) begin
      hidx_r <= hidx_r - 4'h1;
    end
  end

  // Newest entry sits just below the write pointer
  assign hrd = (wptr_r > hidx_r) ? 4'(wptr_r - hidx_r - 4'h1)
                                 : 4'(wptr_r + 4'hA - hidx_r - 4'h1);

  svsq_hist_mem u_hist (
    .clk     (MCLK),
    .rst_b   (RST_B),
    .wr_en   (hist_we),
    .wr_addr (wptr_r),
    .wr_data (hist_wd),
    .rd_addr (hrd),
    .rd_data (hrdata)
  );

  // --------------------------------------------------------------------
  // Sequence decoding from the active word
  // --------------------------------------------------------------------
  logic servo_req, fwd_ok, rev_ok, ot, abn, brake_nxt, servo_nxt;

  assign servo_req = active_r[`SVSQ_B_SERVO] || run_s;
  assign fwd_ok    = active_r[`SVSQ_B_FWD] || !fwd_s;
  assign rev_ok    = active_r[`SVSQ_B_REV] || !rev_s;
  assign ot        = !fwd_ok || !rev_ok;
  // Over-travel with lock keeps the servo on; otherwise it drops once
  // the deceleration has ended
  assign servo_nxt = booted_r && servo_req && !alarm_r &&
                     !(ot && stop_s && !active_r[`SVSQ_B_OTLOCK]);
  // Abnormal stop: alarm, or over-travel using the bit 6 method
  assign abn = alarm_r || (ot && !active_r[`SVSQ_B_OTTORQ]);

  // Brake choice while moving and after the stop
  always_comb begin
    brake_nxt = 1'b0;
    if (abn || !servo_nxt) begin
      if (!stop_s) begin
        brake_nxt = !active_r[`SVSQ_B_FREERUN];
      end else if (active_r[`SVSQ_B_FREERUN] &&
                   !active_r[`SVSQ_B_OTTORQ]) begin
        brake_nxt = 1'b0;
      end else begin
        brake_nxt = active_r[`SVSQ_B_DBHOLD];
      end
    end
  end

  // Registered sequence outputs
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      SERVO_ON                       <= 1'b0;
      SENSOR_ON_INT                  <= 1'b0;
      FWD_PERMIT                     <= 1'b0;
      REV_PERMIT                     <= 1'b0;
      ROTATION_OR_CURRENT_LIMIT_FLAG <= 1'b0;
      DYN_BRAKE                      <= 1'b0;
      ESTOP_TORQUE_SEL               <= 1'b0;
      POS_LOCK                       <= 1'b0;
      SERVO_ALARM                    <= 1'b0;
    end else begin
      SERVO_ON      <= servo_nxt;
      SENSOR_ON_INT <= active_r[`SVSQ_B_SENSOR] || sens_s;
      FWD_PERMIT    <= fwd_ok;
      REV_PERMIT    <= rev_ok;
      ROTATION_OR_CURRENT_LIMIT_FLAG <= active_r[`SVSQ_B_FLAGSEL] ?
                                        clim_s : rot_s;
      DYN_BRAKE     <= brake_nxt;
      ESTOP_TORQUE_SEL <= ot && !alarm_r &&
                          active_r[`SVSQ_B_OTTORQ];
      POS_LOCK      <= servo_nxt && ot && stop_s &&
                       active_r[`SVSQ_B_OTLOCK];
      SERVO_ALARM   <= alarm_r;
    end
  end

  // --------------------------------------------------------------------
  // Display
  // --------------------------------------------------------------------
  svsq_sym_e sym;

  // Alarm outranks everything, then power stage off, then inhibits
  always_comb begin
    if (alarm_r) begin
      sym = SVSQ_S_ALARM;
    end else if (!SERVO_ON) begin
      sym = SVSQ_S_BASEBLOCK;
    end else if (!fwd_ok) begin
      sym = SVSQ_S_FWD_INHIBIT;
    end else if (!rev_ok) begin
      sym = SVSQ_S_REV_INHIBIT;
    end else begin
      sym = SVSQ_S_OPERATING;
    end
  end

  // Display word depends on mode; monitor shows live status bits
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      DISP <= '0;
    end else begin
      DISP.mode    <= mode_r;
      DISP.symbol  <= sym;
      DISP.editing <= edit_on_r;
      DISP.index   <= 4'h0;
      DISP.word    <= 16'h0000;
      DISP.code    <= alm_code_r;
      case (mode_r)
        SVSQ_M_SETTINGS: begin
          DISP.word  <= edit_on_r ? edit_r : 16'(psel_r);
          DISP.index <= idx_r;
        end
        SVSQ_M_MONITOR: begin
          DISP.word <= {7'h00, stop_s, alarm_r, clim_s, rot_s, rev_s,
                        fwd_s, sens_s, run_s, SERVO_ON};
        end
        SVSQ_M_HISTORY: begin
          DISP.index <= hidx_r;
          DISP.code  <= (hidx_r < cnt_r) ? hrdata : 8'h00;
        end
        default: begin
          DISP.word <= 16'h0000;
        end
      endcase
    end
  end

endmodule

//--- svsq_top_assertions.sv
// Property checker for the servo setup and sequence logic
`timescale 1ns/10ps

module svsq_top_assertions (
  // Clock, reset and inputs
  input wire logic                 MCLK,
  input wire logic                 RST_B,
  input wire logic                 RUN_CMD,
  input wire logic                 MOTOR_STOPPED,
  input wire logic                 POWER_DIP,
  input wire logic [15:0]          NV_WORD,
  // Watched outputs
  input wire logic                 NV_WR,
  input wire logic                 SERVO_ON,
  input wire logic                 SENSOR_ON_INT,
  input wire logic                 FWD_PERMIT,
  input wire logic                 DYN_BRAKE,
  input wire logic                 ESTOP_TORQUE_SEL,
  input wire logic                 SERVO_ALARM,
  input wire svsq_pkg::svsq_disp_s DISP
);
  import svsq_pkg::*;

  logic [3:0] up_cnt_r;
  logic       booted;

  // Wait well past the power-up load, so NV_WORD is the active word
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      up_cnt_r <= 4'h0;
    end else if (up_cnt_r != 4'hF) begin
      up_cnt_r <= up_cnt_r + 4'h1;
    end
  end
  assign booted = (up_cnt_r == 4'hF);

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // End of a power dip while the word asks for an alarm
  sequence s_dip_end;
    booted && !NV_WORD[5] && $fell(POWER_DIP);
  endsequence

  a_mode_steps_one: assert property (
    $changed(DISP.mode) |-> DISP.mode == 2'($past(DISP.mode) + 1))
    else $error("mode skipped");
  a_save_one_pulse: assert property (
    NV_WR |-> DISP.editing ##1 !NV_WR)
    else $error("bad save pulse");
  a_servo_by_run: assert property (
    (booted && !NV_WORD[0] && !RUN_CMD) [*5] |-> !SERVO_ON)
    else $error("servo on without run");
  a_sensor_forced: assert property (
    booted && NV_WORD[1] |-> SENSOR_ON_INT)
    else $error("sensor not forced");
  a_fwd_forced: assert property (
    booted && NV_WORD[2] |-> FWD_PERMIT)
    else $error("forward not permitted");
  a_dip_alarm: assert property (
    s_dip_end |-> ##[1:6] SERVO_ALARM)
    else $error("no dip alarm");
  a_estop_needs_bit: assert property (
    ESTOP_TORQUE_SEL |-> NV_WORD[8])
    else $error("stop torque without bit");
  a_brake_released: assert property (
    (booted && NV_WORD[6] && !NV_WORD[8] && MOTOR_STOPPED) [*5]
    |-> !DYN_BRAKE)
    else $error("brake held after free run");
endmodule

bind svsq_top svsq_top_assertions u_chk (
  .MCLK, .RST_B, .RUN_CMD, .MOTOR_STOPPED, .POWER_DIP, .NV_WORD, .NV_WR,
  .SERVO_ON, .SENSOR_ON_INT, .FWD_PERMIT, .DYN_BRAKE, .ESTOP_TORQUE_SEL,
  .SERVO_ALARM, .DISP
);

//--- svsq_top_test.sv
// Self-checking bench for the servo setup and sequence logic
`timescale 1ns/10ps

module svsq_top_test;
  import svsq_pkg::*;

  localparam int KM = 0, KD = 1, KU = 2, KN = 3, KL = 4, KR = 5;
  localparam int KS = 6, KA = 7;
  logic        mclk  = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  key   = 8'h00; // Indexed by the key numbers above
  logic [8:0]  sq    = 9'h070; // Inhibits high, motor rotating
  logic [7:0]  acode = 8'h00;
  logic        nv_ld = 1'b0;
  logic [15:0] nv_pre = 16'h0000;
  logic [15:0] nv_word;
  logic [15:0] nv_wdata;
  logic        nv_wr;
  logic        alarm;
  logic [7:0]  outs;
  svsq_disp_s  disp;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  // Stored word, motor stopped, expected outputs
  logic [15:0] tw [8] = '{16'h0000, 16'h001F, 16'h00C0, 16'h0080,
                          16'h0140, 16'h0201, 16'h0001, 16'h0040};
  logic [7:0]  ts     = 8'b01111100;
  logic [7:0]  te [8] = '{8'h0C, 8'hF0, 8'h08, 8'h0C, 8'h0A, 8'h89, 8'h08,
                          8'h08};

  svsq_top u_dut (
    .MCLK(mclk), .RST_B(rst_b),
    .KEY_MODE(key[0]), .KEY_DATA(key[1]), .KEY_UP(key[2]),
    .KEY_DOWN(key[3]), .KEY_LEFT(key[4]), .KEY_RIGHT(key[5]),
    .KEY_SAVE(key[6]), .KEY_ALARM_RESET(key[7]),
    .RUN_CMD(sq[8]), .SENSOR_ON(sq[7]), .FORWARD_DRIVE_INHIBIT(sq[6]),
    .REVERSE_DRIVE_INHIBIT(sq[5]), .MOTOR_ROTATING(sq[4]),
    .CURRENT_LIMIT(sq[3]), .MOTOR_STOPPED(sq[2]), .POWER_DIP(sq[1]),
    .ALARM_IN(sq[0]), .ALARM_CODE(acode),
    .NV_WORD(nv_word), .NV_WR(nv_wr), .NV_WDATA(nv_wdata),
    .SERVO_ON(outs[7]), .SENSOR_ON_INT(outs[6]), .FWD_PERMIT(outs[5]),
    .REV_PERMIT(outs[4]), .ROTATION_OR_CURRENT_LIMIT_FLAG(outs[3]),
    .DYN_BRAKE(outs[2]), .ESTOP_TORQUE_SEL(outs[1]), .POS_LOCK(outs[0]),
    .SERVO_ALARM(alarm), .DISP(disp)
  );

  svsq_nv_model u_nv (
    .clk(mclk), .rst_b(rst_b), .ld(nv_ld), .ld_word(nv_pre),
    .wr(nv_wr), .wdata(nv_wdata), .word(nv_word)
  );

  // 25 MHz clock
  initial begin
    forever begin
      #20 mclk = ~mclk;
    end
  end

  // The run needs about 810 cycles; a hang is cut off well beyond
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      summarize();
    end
  end

  // Inputs always change 2 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // Held two cycles, then released until the display has settled
  task automatic press(input int k);
    key[k] = 1'b1;
    tick(2);
    key[k] = 1'b0;
    tick(6);
  endtask

  // Power cycle with the given word in the store
  task automatic power_up(input logic [15:0] w);
    rst_b = 1'b0;
    nv_ld = 1'b1;
    nv_pre = w;
    tick(16);
    nv_ld = 1'b0;
    rst_b = 1'b1;
    tick(16);
  endtask

  task automatic dip();
    sq[1] = 1'b1;
    tick(4);
    sq[1] = 1'b0;
    tick(8);
  endtask

  task automatic chk(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    int i;
    power_up(16'h00EC);
    chk("nv_wdata", 16'h00EC, nv_wdata);
    sq[8] = 1'b1;
    tick(6);
    chk("factory", 16'h00B8, outs);
    for (i = 1; i <= 4; i++) begin
      press(KM);
      chk("mode", 16'(i % 4), disp.mode);
    end
    // Word one: toggle bits 0 and 1, walk the index to both ends
    press(KM);
    press(KU);
    press(KD);
    chk("edit copy", 16'h00EC, disp.word);
    press(KU);
    press(KL);
    press(KN);
    press(KR);
    press(KR);
    chk("index floor", 16'h0000, disp.index);
    repeat (16) press(KL);
    chk("index top", 16'h000F, disp.index);
    chk("edit word", 16'h00EF, disp.word);
    chk("unsaved", 16'h00EC, u_nv.mem);
    press(KS);
    chk("saved", 16'h00EF, u_nv.mem);
    chk("outs kept", 16'h00B8, outs);
    press(KD);
    chk("number view", 16'h0001, disp.word);
    chk("editing off", 16'h0000, disp.editing);
    sq[8] = 1'b0;
    power_up(16'h00EF);
    chk("reloaded", 16'h00F8, outs);
    for (i = 0; i < 8; i++) begin
      power_up(tw[i]);
      sq[2] = ts[i];
      tick(8);
      chk("sequence", {8'h00, te[i]}, outs);
      chk("brake", te[i][2], outs[2]);
    end
    // Dip recovery raising an alarm, history, reset and clear
    power_up(16'h0000);
    sq[2] = 1'b0;
    dip();
    chk("dip alarm", 16'h0001, alarm);
    chk("symbol", 16'(SVSQ_S_ALARM), disp.symbol);
    // External alarm with its own code lands as the newest entry
    acode = 8'h5A;
    sq[0] = 1'b1;
    tick(8);
    sq[0] = 1'b0;
    tick(4);
    chk("alarm code", 16'h005A, disp.code);
    repeat (3) press(KM);
    chk("history", 16'h005A, disp.code);
    press(KU);
    chk("history older", 16'h0010, disp.code);
    press(KM);
    press(KA);
    chk("alarm reset", 16'h0000, alarm);
    press(KM);
    press(KD);
    repeat (2) press(KM);
    chk("history clear", 16'h0000, disp.code);
    power_up(16'h0020);
    dip();
    chk("dip auto clear", 16'h0000, alarm);
    summarize();
  end
endmodule
